// >>> src/haptic_waveform_sequencer_slots.sv
// Waveform sequencer slot registers, software trigger and slot walking engine.
//
// Functional notes
// - Delay flag set: idle for entry times 10 ms.
// - Delay flag clear: entry is waveform index.
// - Index names a waveform in selected library.
// - Trigger starts playback at first slot, sequence_slot_one.
// - After a waveform, move to next slot.
// - At most eight slots, sequence_slot_one through 0x16.
// - Zero entry ends the sequence, plays nothing.
// - First slot resets to entry one, flag clear.
// - Trigger clears itself at sequence end; clearing it cancels playback.
// - External trigger sets the trigger bit too.
`timescale 1ns/10ps
`default_nettype none
`include "haptic_seq_defines.svh"

module haptic_waveform_sequencer_slots
  import haptic_seq_pkg::*;
#(
  parameter int NUM_SLOTS   = `SLOT_COUNT,
  parameter int STEP_CYCLES = `DELAY_STEP_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic       ext_trigger,
  input  wire logic       play_done,
  output logic            play_start,
  output logic      [6:0] play_index,
  output logic            play_abort,
  output logic            idle_active,
  output logic            seq_busy
);

  // Refuse parameter values that the counters and slot array cannot hold.
  if (NUM_SLOTS < 1 || NUM_SLOTS > `SLOT_COUNT) begin : g_bad_slots
    $error("NUM_SLOTS must lie between 1 and the slot array size.");
  end
  if (STEP_CYCLES < 1 || STEP_CYCLES >= (1 << `STEP_CNT_W)) begin : g_bad_step
    $error("STEP_CYCLES does not fit the delay step counter.");
  end

  localparam logic [`STEP_CNT_W-1:0] STEP_LAST = `STEP_CNT_W'(STEP_CYCLES - 1); // Last count of one step.
  localparam logic [3:0]             PTR_END   = 4'(NUM_SLOTS);                 // Pointer value past the last slot.

  seq_st_t st;  // Registered state.
  seq_st_t nx;  // Next state.

  // Maps a register address to a slot number; the top bit flags a hit.
  function automatic logic [3:0] slot_decode(input logic [7:0] addr);
    logic [7:0] rel;
    rel = addr - `SLOT_BASE_OFFSET;
    if (addr >= `SLOT_BASE_OFFSET && addr <= `SLOT_LAST_OFFSET) begin
      slot_decode = {1'b1, rel[2:0]};
    end else begin
      slot_decode = 4'h0;
    end
  endfunction

  // Next-state logic: register access, trigger bit and slot walking.
  always_comb begin
    logic [3:0] wdec;
    logic [3:0] rdec;
    slot_t      cur;
    logic       done_seq;
    wdec     = slot_decode(reg_addr);
    rdec     = slot_decode(reg_addr);
    cur      = st.slots[st.ptr[2:0]];
    done_seq = 1'b0;
    nx            = st;
    nx.play_start = 1'b0;
    nx.play_abort = 1'b0;

    // Slot writes are accepted at any time; a slot not yet reached uses the new value.
    if (reg_wr && wdec[3]) begin
      nx.slots[wdec[2:0]] = reg_wdata;
    end

    // Read data is held until the next read strobe; unmapped addresses return zero.
    if (reg_rd) begin
      if (rdec[3]) begin
        nx.rdata = st.slots[rdec[2:0]];
      end else if (reg_addr == `TRIGGER_CTRL_OFFSET) begin
        nx.rdata = {7'h00, st.go};
      end else begin
        nx.rdata = 8'h00;
      end
    end

    // Walk the slots.
    case (st.state)
      S_IDLE: begin
        if (st.go) begin
          nx.state = S_FETCH;
          nx.ptr   = 4'h0;
        end
      end
      S_FETCH: begin
        if (st.ptr >= PTR_END) begin
          done_seq = 1'b1;
        end else if (cur.entry == 7'h00) begin
          done_seq = 1'b1;
        end else if (cur.delay_flag) begin
          nx.state     = S_WAIT;
          nx.wait_left = cur.entry;
          nx.step_cnt  = '0;
        end else begin
          // The index passes untouched; the engine looks it up in the selected library.
          nx.play_start = 1'b1;
          nx.play_index = cur.entry;
          nx.state      = S_PLAY;
        end
      end
      S_PLAY: begin
        if (play_done) begin
          nx.state = S_FETCH;
          nx.ptr   = st.ptr + 4'h1;
        end
      end
      S_WAIT: begin
        // One step of the delay is STEP_CYCLES clocks; no waveform is driven meanwhile.
        if (st.step_cnt == STEP_LAST) begin
          nx.step_cnt = '0;
          if (st.wait_left == 7'h01) begin
            nx.state = S_FETCH;
            nx.ptr   = st.ptr + 4'h1;
          end else begin
            nx.wait_left = st.wait_left - 7'h01;
          end
        end else begin
          nx.step_cnt = st.step_cnt + `STEP_CNT_W'(1);
        end
      end
      default: begin
        nx.state = S_IDLE;
      end
    endcase

    // Host clearing the trigger mid-sequence cancels at once.
    if (st.state != S_IDLE && !st.go) begin
      nx.state      = S_IDLE;
      nx.play_start = 1'b0;
      nx.play_abort = (st.state == S_PLAY) || (st.state == S_WAIT);
      done_seq      = 1'b0;
    end

    // Trigger bit: hardware clear at completion, then host write, then the set from the pin wins.
    if (done_seq) begin
      nx.go    = 1'b0;
      nx.state = S_IDLE;
    end
    if (reg_wr && reg_addr == `TRIGGER_CTRL_OFFSET) begin
      nx.go = reg_wdata[`TRIGGER_GO_BIT];
    end
    if (ext_trigger) begin
      nx.go = 1'b1;
    end
  end

  // State register with synchronous reset.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st          <= '0;
      st.slots[0] <= `SLOT_ONE_RESET;
      st.state    <= S_IDLE;
    end else begin
      st <= nx;
    end
  end

  // Outputs come straight from state flops; seq_busy is the inverted S_IDLE state bit.
  assign reg_rdata   = st.rdata;
  assign play_start  = st.play_start;
  assign play_index  = st.play_index;
  assign play_abort  = st.play_abort;
  assign idle_active = st.state[3];
  assign seq_busy    = ~st.state[0];

  // Slot under the pointer, kept as a net so that the assertions see its sampled value.
  slot_t cur_slot;
  assign cur_slot = st.slots[st.ptr[2:0]];

  property p_start;
    @(posedge clk) disable iff (!rst_n)
      (st.state == S_IDLE && st.go) |=> (st.state == S_FETCH && st.ptr == 4'h0);
  endproperty
  a_start: assert property (p_start) else $error("Trigger did not start at the first slot.");

  property p_play;
    @(posedge clk) disable iff (!rst_n)
      (st.state == S_FETCH && st.go && st.ptr < PTR_END && !cur_slot.delay_flag && cur_slot.entry != 7'h00)
        |=> (play_start && play_index == $past(cur_slot.entry) && st.state == S_PLAY);
  endproperty
  a_play: assert property (p_play) else $error("Waveform slot did not start its index.");

  property p_wait;
    @(posedge clk) disable iff (!rst_n)
      (st.state == S_FETCH && st.go && st.ptr < PTR_END && cur_slot.delay_flag && cur_slot.entry != 7'h00)
        |=> (idle_active && !play_start && st.wait_left == $past(cur_slot.entry));
  endproperty
  a_wait: assert property (p_wait) else $error("Delay slot did not enter the idle period.");

  property p_zero_stop;
    @(posedge clk) disable iff (!rst_n)
      (st.state == S_FETCH && st.go && st.ptr < PTR_END && cur_slot.entry == 7'h00 && !ext_trigger
        && !(reg_wr && reg_addr == `TRIGGER_CTRL_OFFSET))
        |=> (st.state == S_IDLE && !st.go && !play_start);
  endproperty
  a_zero_stop: assert property (p_zero_stop) else $error("Zero entry did not end the sequence.");

  property p_advance;
    @(posedge clk) disable iff (!rst_n)
      (st.state == S_PLAY && st.go && play_done) |=> (st.state == S_FETCH && st.ptr == $past(st.ptr) + 4'h1);
  endproperty
  a_advance: assert property (p_advance) else $error("Sequencer did not move to the next slot.");

  property p_limit;
    @(posedge clk) disable iff (!rst_n)
      (st.state == S_FETCH && st.ptr >= PTR_END) |=> (st.state == S_IDLE && !play_start);
  endproperty
  a_limit: assert property (p_limit) else $error("Playback ran past the last slot.");

  property p_reset_slot;
    @(posedge clk) $past(!rst_n) |-> (st.slots[0] == 8'h01 && st.state == S_IDLE);
  endproperty
  a_reset_slot: assert property (p_reset_slot) else $error("First slot reset value wrong.");

  property p_cancel;
    @(posedge clk) disable iff (!rst_n)
      (st.state == S_PLAY && !st.go) |=> (st.state == S_IDLE && play_abort) ##1 !play_abort;
  endproperty
  a_cancel: assert property (p_cancel) else $error("Clearing the trigger did not cancel playback.");

  property p_ext;
    @(posedge clk) disable iff (!rst_n) ext_trigger |=> st.go;
  endproperty
  a_ext: assert property (p_ext) else $error("External trigger did not set the trigger bit.");

  property p_continue;
    @(posedge clk) disable iff (!rst_n)
      (st.state == S_WAIT && st.go && st.wait_left == 7'h01 && st.step_cnt == STEP_LAST)
        |=> (st.state == S_FETCH && st.ptr == $past(st.ptr) + 4'h1);
  endproperty
  a_continue: assert property (p_continue) else $error("Delay slot did not continue the sequence.");

endmodule
`default_nettype wire

// >>> src/haptic_seq_defines.svh
// Offsets, field positions, reset values and timing counts of the waveform sequencer slots.
`ifndef HAPTIC_SEQ_DEFINES_SVH
`define HAPTIC_SEQ_DEFINES_SVH

`define TRIGGER_CTRL_OFFSET  8'h0c
`define TRIGGER_GO_BIT       0
`define SLOT_BASE_OFFSET     8'h0f
`define SLOT_TWO_OFFSET      8'h10
`define SLOT_LAST_OFFSET     8'h16
`define SLOT_COUNT           8
`define SLOT_FLAG_BIT        7
`define SLOT_VALUE_MSB       6
`define SLOT_ONE_RESET       8'h01
`define SLOT_OTHER_RESET     8'h00
`define CLK_PERIOD_NS        50
`define DELAY_STEP_MS        10
`define DELAY_STEP_CYCLES    ((`DELAY_STEP_MS * 1000000) / `CLK_PERIOD_NS)
`define STEP_CNT_W           24

`endif

// >>> src/haptic_seq_pkg.sv
// Types shared by the waveform sequencer slot logic.
`include "haptic_seq_defines.svh"

package haptic_seq_pkg;

  // One sequence slot: delay flag above a seven-bit entry.
  typedef struct packed {
    logic       delay_flag;
    logic [6:0] entry;
  } slot_t;

  // Sequencer states, one-hot.
  typedef enum logic [3:0] {
    S_IDLE  = 4'b0001,
    S_FETCH = 4'b0010,
    S_PLAY  = 4'b0100,
    S_WAIT  = 4'b1000
  } seq_state_t;

  // Complete state of the sequencer module.
  typedef struct packed {
    slot_t [`SLOT_COUNT-1:0] slots;
    logic                    go;
    seq_state_t              state;
    logic [3:0]              ptr;
    logic [`STEP_CNT_W-1:0]  step_cnt;
    logic [6:0]              wait_left;
    logic [7:0]              rdata;
    logic                    play_start;
    logic [6:0]              play_index;
    logic                    play_abort;
  } seq_st_t;

endpackage

// >>> tb/playback_model.sv
// Playback engine model that answers each waveform start with a done pulse.
`timescale 1ns/10ps
`default_nettype none

module playback_model #(
  parameter int PLAY_CYCLES = 6
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic play_start,
  input  wire logic play_abort,
  input  wire logic stall,
  output logic      play_done
);
  int cnt; // Cycles left in the waveform now playing, zero when idle.

  // A stalled engine never finishes, so only a cancel can end the sequence.
  always_ff @(posedge clk) begin
    play_done <= 1'b0;
    if (!rst_n || play_abort) begin
      cnt <= 0;
    end else if (play_start) begin
      cnt <= PLAY_CYCLES;
    end else if (cnt == 1 && !stall) begin
      play_done <= 1'b1;
      cnt <= 0;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule

`default_nettype wire

// >>> tb/tb.sv
// Self-checking bench for the sequencer slots against a playback engine model.
`timescale 1ns/10ps
`default_nettype none

module tb;
  localparam int STEP = 4; // Short delay step keeps delay slots brief.
  logic       clk, rst_n, reg_wr, reg_rd, ext_trigger, stall;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
  logic       play_done, play_start, play_abort, idle_active, seq_busy;
  logic [6:0] play_index;
  logic [6:0] idx_q[$]; // Waveform indices started, in order.
  int         num_errors, checks, idle_cnt, abort_cnt;

  haptic_waveform_sequencer_slots #(.STEP_CYCLES(STEP)) haptic_waveform_sequencer_slots_i (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .ext_trigger(ext_trigger), .play_done(play_done),
    .play_start(play_start), .play_index(play_index), .play_abort(play_abort),
    .idle_active(idle_active), .seq_busy(seq_busy));
  playback_model playback_model_i (.clk(clk), .rst_n(rst_n), .play_start(play_start),
    .play_abort(play_abort), .stall(stall), .play_done(play_done));

  // Free-running clock at 50 ns.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Log what the sequencer hands to the engine, sampled mid-cycle where values are settled.
  always @(negedge clk) begin
    if (play_start === 1'b1) idx_q.push_back(play_index);
    if (idle_active === 1'b1) idle_cnt++;
    if (play_abort === 1'b1) abort_cnt++;
  end

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Read data lands one cycle after the strobe edge and then holds.
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    #1;
    v = reg_rdata;
  endtask

  // Waits for busy to rise and fall again, under a bound.
  task automatic wait_done();
    int n;
    n = 0;
    while (seq_busy !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    while (seq_busy !== 1'b0 && n < 3000) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk8(8'(n < 3000), 8'h01);
    idx_q.delete();
    idle_cnt = 0;
    abort_cnt = 0;
  endtask

  task automatic test_reset_values();
    rd(8'h0f); chk8(v, 8'h01);
    rd(8'h10); chk8(v, 8'h00);
    rd(8'h0c); chk8(v, 8'h00);
    wr(8'h20, 8'hff);
    rd(8'h20); chk8(v, 8'h00);
  endtask

  // Trigger with reset slots: waveform one plays, then the zero slot stops.
  task automatic test_default_trigger();
    wr(8'h0c, 8'h01);
    repeat (2) @(posedge clk);
    #1;
    chk8({7'h00, play_start}, 8'h01);
    chk8({1'b0, play_index}, 8'h01);
    repeat (12) @(posedge clk);
    #1;
    chk8(8'(idx_q.size()), 8'h01);
    chk8({7'h00, seq_busy}, 8'h00);
    wait_done();
    rd(8'h0c); chk8(v, 8'h00);
  endtask

  // Eight slots with a delay in slot three, started by the external trigger.
  task automatic test_full_walk();
    logic [6:0] e [7] = '{7'h01, 7'h02, 7'h04, 7'h05, 7'h06, 7'h07, 7'h08};
    for (int i = 0; i < 8; i++) wr(8'h0f + 8'(i), (i == 2) ? 8'h82 : 8'(i + 1));
    rd(8'h16); chk8(v, 8'h08);
    @(posedge clk);
    ext_trigger <= 1'b1;
    @(posedge clk);
    ext_trigger <= 1'b0;
    repeat (200) @(posedge clk);
    #1;
    chk8(8'(idx_q.size()), 8'h07);
    for (int i = 0; i < 7; i++) chk8({1'b0, idx_q[i]}, {1'b0, e[i]});
    chk8(8'(idle_cnt), 8'(2 * STEP));
    chk8({7'h00, seq_busy}, 8'h00);
    wait_done();
  endtask

  // The engine stalls; clearing the trigger must cancel at once.
  task automatic test_cancel();
    @(posedge clk);
    stall <= 1'b1;
    wr(8'h0c, 8'h01);
    rd(8'h0c); chk8(v, 8'h01);
    wr(8'h0c, 8'h00);
    repeat (4) @(posedge clk);
    #1;
    chk8({7'h00, seq_busy}, 8'h00);
    chk8(8'(abort_cnt), 8'h01);
    @(posedge clk);
    stall <= 1'b0;
    // A long delay in the first slot is cancelled in the middle of its idle period.
    wr(8'h0f, 8'h85);
    wr(8'h0c, 8'h01);
    repeat (4) @(posedge clk);
    #1;
    chk8({7'h00, idle_active}, 8'h01);
    wr(8'h0c, 8'h00);
    repeat (3) @(posedge clk);
    #1;
    chk8({6'h00, idle_active, seq_busy}, 8'h00);
    chk8(8'(abort_cnt), 8'h02);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // The whole run needs well under two thousand cycles.
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    tally_and_finish();
  end

  initial begin
    {rst_n, reg_wr, reg_rd, ext_trigger, stall} = '0;
    {reg_addr, reg_wdata, num_errors, checks, idle_cnt, abort_cnt} = '0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    test_reset_values();
    test_default_trigger();
    test_full_walk();
    test_cancel();
    tally_and_finish();
  end
endmodule

`default_nettype wire
